// ---- design/core_op_exec.sv ----
`timescale 1ns/1ns


module core_op_exec #(
   parameter int W = core_op_pkg::DATA_W,
   parameter int FA_W = core_op_pkg::FILE_AW,
   parameter int PCW = core_op_pkg::PC_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // operation issue
   input wire logic op_valid,
   input core_op_pkg::op_t op,
   input wire logic [W-1:0] op_literal,
   input wire logic [FA_W-1:0] op_file,
   input wire logic op_dest,
   output logic op_ready,
   // file registers
   output logic [FA_W-1:0] file_raddr,
   input wire logic [W-1:0] file_rdata,
   output logic file_we,
   output logic [FA_W-1:0] file_waddr,
   output logic [W-1:0] file_wdata,
   // stack and program counter
   input wire logic [PCW-1:0] stack_head,
   output logic stack_pop,
   output logic pc_load,
   output logic [PCW-1:0] pc_value,
   output logic fetch_discard,
   // watchdog and power
   input wire logic wake,
   output logic watchdog_clear,
   output logic asleep,
   output logic timeout_flag,
   output logic power_down_flag,
   // accumulator and status
   output logic [W-1:0] acc,
   output logic borrow_inverse_flag,
   output logic half_borrow_inverse_flag,
   output logic null_result_flag
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (W <= core_op_pkg::NIBBLE_W) begin : g_bad_w
      $error("data width must exceed one nibble");
   end
   if (W > 8) begin : g_big_w
      $error("reset constants cover at most 8 bits");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {
      st_run,
      st_flush,
      st_sleep
   } phase_t;

   typedef struct packed {
      phase_t ph;
      logic [W-1:0] acc;
      logic c;
      logic half;
      logic z;
      logic tmo;
      logic pwr_down;
      logic wclr;
      logic pop;
      logic pcl;
      logic disc;
      logic [PCW-1:0] pc;
      logic fwe;
      logic [FA_W-1:0] fa;
      logic [W-1:0] fwd;
   } state_t;

   localparam state_t RST_VAL = '{
      ph: st_run,
      acc: core_op_pkg::ACC_RST[W-1:0],
      c: core_op_pkg::CARRY_RST,
      half: core_op_pkg::HALF_RST,
      z: core_op_pkg::NULL_RST,
      tmo: core_op_pkg::TIMEOUT_RST,
      pwr_down: core_op_pkg::POWER_DOWN_RST,
      wclr: 1'b0,
      pop: 1'b0,
      pcl: 1'b0,
      disc: 1'b0,
      pc: '0,
      fwe: 1'b0,
      fa: '0,
      fwd: '0
   };

   state_t s_q;
   state_t s_d;
   logic accept;

   alu_if #(.W(W)) alu ();

   sub_rot_alu #(.W(W)) u_alu (
      .a(alu.alu)
   );

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic reads_file(input core_op_pkg::op_t o);
      return (o == core_op_pkg::op_file_minus) || (o == core_op_pkg::op_rotate);
   endfunction : reads_file

   // ----------------------------------------
   // operand routing
   // ----------------------------------------
   assign op_ready = (s_q.ph == st_run);
   assign accept = op_valid && op_ready;
   assign file_raddr = op_file;

   always_comb begin
      alu.lhs = reads_file(op) ? file_rdata : op_literal;
      alu.rhs = s_q.acc;
      alu.rot = (op == core_op_pkg::op_rotate);
      alu.cin = s_q.c;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.wclr = 1'b0;
      s_d.pop = 1'b0;
      s_d.pcl = 1'b0;
      s_d.disc = 1'b0;
      s_d.fwe = 1'b0;
      unique case (s_q.ph)
         st_run: begin
            if (op_valid) begin
               unique case (op)
                  core_op_pkg::op_halt: begin
                     s_d.wclr = 1'b1;
                     s_d.pwr_down = core_op_pkg::POWER_DOWN_ON_HALT;
                     s_d.tmo = core_op_pkg::TIMEOUT_ON_HALT;
                     s_d.ph = st_sleep;
                  end
                  core_op_pkg::op_sub_exit: begin
                     s_d.pop = 1'b1;
                     s_d.pcl = 1'b1;
                     s_d.pc = stack_head;
                     s_d.disc = 1'b1;
                     s_d.ph = st_flush;
                  end
                  core_op_pkg::op_lit_minus: begin
                     s_d.acc = alu.res;
                     s_d.c = alu.c;
                     s_d.half = alu.half;
                     s_d.z = alu.z;
                  end
                  core_op_pkg::op_file_minus: begin
                     s_d.c = alu.c;
                     s_d.half = alu.half;
                     s_d.z = alu.z;
                     if (op_dest == core_op_pkg::DEST_FILE) begin
                        s_d.fwe = 1'b1;
                        s_d.fa = op_file;
                        s_d.fwd = alu.res;
                     end else begin
                        s_d.acc = alu.res;
                     end
                  end
                  core_op_pkg::op_rotate: begin
                     s_d.c = alu.c;
                     if (op_dest == core_op_pkg::DEST_FILE) begin
                        s_d.fwe = 1'b1;
                        s_d.fa = op_file;
                        s_d.fwd = alu.res;
                     end else begin
                        s_d.acc = alu.res;
                     end
                  end
                  core_op_pkg::op_none: begin
                  end
                  default: begin
                  end
               endcase
            end
         end
         st_flush: begin
            s_d.ph = st_run;
         end
         st_sleep: begin
            if (wake) begin
               s_d.ph = st_run;
            end
         end
         default: begin
            s_d.ph = st_run;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= RST_VAL;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign file_we = s_q.fwe;
   assign file_waddr = s_q.fa;
   assign file_wdata = s_q.fwd;
   assign stack_pop = s_q.pop;
   assign pc_load = s_q.pcl;
   assign pc_value = s_q.pc;
   assign fetch_discard = s_q.disc;
   assign watchdog_clear = s_q.wclr;
   assign asleep = (s_q.ph == st_sleep);
   assign timeout_flag = s_q.tmo;
   assign power_down_flag = s_q.pwr_down;
   assign acc = s_q.acc;
   assign borrow_inverse_flag = s_q.c;
   assign half_borrow_inverse_flag = s_q.half;
   assign null_result_flag = s_q.z;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   localparam int NW = core_op_pkg::NIBBLE_W;

   logic is_halt;
   logic is_exit;
   logic is_lit;
   logic is_fsub;
   logic is_rot;
   assign is_halt = accept && (op == core_op_pkg::op_halt);
   assign is_exit = accept && (op == core_op_pkg::op_sub_exit);
   assign is_lit = accept && (op == core_op_pkg::op_lit_minus);
   assign is_fsub = accept && (op == core_op_pkg::op_file_minus);
   assign is_rot = accept && (op == core_op_pkg::op_rotate);

   AST_WATCHDOG_CLEAR: assert property (
      is_halt |=> watchdog_clear ##1 !watchdog_clear)
      else $error("watchdog not cleared once on halt");

   AST_POWER_DOWN_LOW: assert property (
      is_halt |=> !power_down_flag && asleep)
      else $error("power down flag not low after halt");

   AST_TIMEOUT_HIGH: assert property (
      is_halt |=> timeout_flag)
      else $error("timeout flag not high after halt");

   AST_SLEEP_HOLD: assert property (
      asleep && !wake |=> asleep && !op_ready && !file_we)
      else $error("core left sleep without wake");

   AST_POP_PC: assert property (
      is_exit |=> stack_pop && pc_load && pc_value == $past(stack_head))
      else $error("exit did not pop stack into pc");

   AST_TWO_CYCLE: assert property (
      is_exit |-> op_ready ##1 (!op_ready && fetch_discard) ##1 op_ready)
      else $error("exit not two cycles");

   AST_LIT_SUB: assert property (
      is_lit |=> acc == W'($past(op_literal) - $past(acc)))
      else $error("literal minus accumulator wrong");

   AST_FILE_FLAGS: assert property (
      is_fsub |=> borrow_inverse_flag == ($past(file_rdata) >= $past(acc))
         && null_result_flag == ($past(file_rdata) == $past(acc)))
      else $error("file subtract flags wrong");

   AST_FILE_DEST: assert property (
      is_fsub && op_dest |=> file_we && acc == $past(acc)
         && file_wdata == W'($past(file_rdata) - $past(acc)))
      else $error("file subtract destination wrong");

   AST_ROT_FLAG: assert property (
      is_rot |=> borrow_inverse_flag == $past(file_rdata[0])
         && $stable(null_result_flag) && $stable(half_borrow_inverse_flag))
      else $error("rotate flag wrong");

   AST_ROT_DEST: assert property (
      is_rot && !op_dest |=> !file_we
         && acc == {$past(borrow_inverse_flag), $past(file_rdata[W-1:1])})
      else $error("rotate to accumulator wrong");

   AST_HALF_FLAG: assert property (
      is_lit |=> half_borrow_inverse_flag == ($past(op_literal[NW-1:0]) >= $past(acc[NW-1:0])))
      else $error("half borrow flag wrong");

   COV_HALT_WAKE: cover property (is_halt ##1 asleep [*2] ##1 !asleep);
   COV_EXIT: cover property (is_exit ##2 accept);
   COV_FILE_BACK: cover property (is_fsub && op_dest ##1 file_we);
   COV_ROT_ACC: cover property (is_rot && !op_dest);

endmodule : core_op_exec

// ---- pkg/core_op_pkg.sv ----
package core_op_pkg;

   // ----------------------------------------
   // operations decoded upstream
   // ----------------------------------------
   typedef enum logic [2:0] {
      op_none,
      op_halt,
      op_sub_exit,
      op_lit_minus,
      op_file_minus,
      op_rotate
   } op_t;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int FILE_AW = 7;
   localparam int PC_W = 13;
   localparam int NIBBLE_W = 4;

   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic CARRY_RST = 1'h0;
   localparam logic HALF_RST = 1'h0;
   localparam logic NULL_RST = 1'h0;
   localparam logic TIMEOUT_RST = 1'h1;
   localparam logic POWER_DOWN_RST = 1'h1;

   // ----------------------------------------
   // values written by the halt operation
   // ----------------------------------------
   localparam logic [7:0] WATCHDOG_CLEAR_VAL = 8'h00;
   localparam logic TIMEOUT_ON_HALT = 1'h1;
   localparam logic POWER_DOWN_ON_HALT = 1'h0;

   // ----------------------------------------
   // cycle counts
   // ----------------------------------------
   localparam int SUB_EXIT_CYCLES = 2;

   // ----------------------------------------
   // destination select encoding
   // ----------------------------------------
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_FILE = 1'h1;

endpackage : core_op_pkg

// ---- pkg/alu_if.sv ----
`timescale 1ns/1ns

interface alu_if #(
   parameter int W = 8
);
   logic [W-1:0] lhs;
   logic [W-1:0] rhs;
   logic rot;
   logic cin;
   logic [W-1:0] res;
   logic c;
   logic half;
   logic z;

   modport exec (
      output lhs,
      output rhs,
      output rot,
      output cin,
      input res,
      input c,
      input half,
      input z
   );

   modport alu (
      input lhs,
      input rhs,
      input rot,
      input cin,
      output res,
      output c,
      output half,
      output z
   );
endinterface : alu_if

// ---- design/sub_rot_alu.sv ----
`timescale 1ns/1ns

module sub_rot_alu #(
   parameter int W = 8
) (
   alu_if.alu a
);

   localparam int NW = core_op_pkg::NIBBLE_W;

   logic [W:0] diff;
   logic [NW:0] ndiff;

   if (W <= NW) begin : g_bad_w
      $error("data width must exceed one nibble");
   end

   // ----------------------------------------
   // subtract by adding the inverted operand plus one
   // ----------------------------------------
   always_comb begin
      diff = {1'b0, a.lhs} + {1'b0, ~a.rhs} + {{W{1'b0}}, 1'b1};
      ndiff = {1'b0, a.lhs[NW-1:0]} + {1'b0, ~a.rhs[NW-1:0]} + {{NW{1'b0}}, 1'b1};
      if (a.rot) begin
         a.res = {a.cin, a.lhs[W-1:1]};
         a.c = a.lhs[0];
      end else begin
         a.res = diff[W-1:0];
         a.c = diff[W];
      end
      a.half = ndiff[NW];
      a.z = (diff[W-1:0] == '0);
   end

endmodule : sub_rot_alu

// ---- testbench/file_stack_model.sv ----
`timescale 1ns/1ns

module file_stack_model (
   // clock
   input wire logic clk,
   // file registers
   input wire logic [6:0] raddr,
   output logic [7:0] rdata,
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [7:0] wdata,
   // stack
   output logic [12:0] head,
   input wire logic pop
);
   logic [7:0] mem [0:127];
   logic [12:0] stk [0:7];
   logic [2:0] sp = 3'h7;

   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i * 37 + 11);
      end
      for (int i = 0; i < 8; i++) begin
         stk[i] = 13'(i * 1031 + 341);
      end
   end

   // read data follows the address in the same cycle
   assign rdata = mem[raddr];
   assign head = stk[sp];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (pop) begin
         sp <= sp - 3'h1;
      end
   end
endmodule : file_stack_model

// ---- testbench/core_op_exec_tb.sv ----
`timescale 1ns/1ns

module core_op_exec_tb;
   // ---------------------------------------
   // signals
   // ---------------------------------------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic op_valid = 1'h0;
   core_op_pkg::op_t op = core_op_pkg::op_none;
   logic [7:0] op_literal = 8'h00;
   logic [6:0] op_file = 7'h00;
   logic op_dest = 1'h0;
   logic wake = 1'h0;
   logic op_ready, file_we, stack_pop, pc_load, fetch_discard, watchdog_clear, asleep;
   logic timeout_flag, power_down_flag, borrow_inverse_flag, half_borrow_inverse_flag, null_result_flag;
   logic [6:0] file_raddr, file_waddr;
   logic [7:0] file_rdata, file_wdata, acc;
   logic [12:0] stack_head, pc_value;
   logic [7:0] e_acc = 8'h00;
   logic e_c = 1'h0;
   logic e_half = 1'h0;
   logic [7:0] lits [0:5] = '{8'h00, 8'h05, 8'h03, 8'h10, 8'hFF, 8'h80};
   logic e_z = 1'h0;
   int mismatches = 0;
   int n_checks = 0;

   always #4 clk = ~clk;

   core_op_exec uut (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .op_literal(op_literal),
      .op_file(op_file), .op_dest(op_dest), .op_ready(op_ready), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
      .stack_head(stack_head), .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
      .fetch_discard(fetch_discard), .wake(wake), .watchdog_clear(watchdog_clear), .asleep(asleep),
      .timeout_flag(timeout_flag), .power_down_flag(power_down_flag), .acc(acc),
      .borrow_inverse_flag(borrow_inverse_flag), .half_borrow_inverse_flag(half_borrow_inverse_flag),
      .null_result_flag(null_result_flag));

   file_stack_model far (.clk(clk), .raddr(file_raddr), .rdata(file_rdata), .we(file_we),
      .waddr(file_waddr), .wdata(file_wdata), .head(stack_head), .pop(stack_pop));

   // ---------------------------------------
   // helpers
   // ---------------------------------------
   task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   // returns no-borrow, no-nibble-borrow, difference
   function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'h0, a} + {1'h0, ~b} + 9'h001;
      low = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + 5'h01;
      return {full[8], low[4], full[7:0]};
   endfunction : sub8

   // ---------------------------------------
   // scenarios
   // ---------------------------------------
   task automatic run(input core_op_pkg::op_t o, input logic [7:0] k, input logic [6:0] f, input logic d);
      logic [9:0] r;
      logic to_file;
      @(negedge clk);
      to_file = (o != core_op_pkg::op_lit_minus) && d;
      if (o == core_op_pkg::op_rotate) begin
         r = {far.mem[f][0], e_half, e_c, far.mem[f][7:1]};
      end else begin
         r = sub8((o == core_op_pkg::op_lit_minus) ? k : far.mem[f], e_acc);
         e_z = (r[7:0] == 8'h00);
      end
      e_c = r[9];
      e_half = r[8];
      if (!to_file) begin
         e_acc = r[7:0];
      end
      op_valid = 1'h1;
      op = o;
      op_literal = k;
      op_file = f;
      op_dest = d;
      @(negedge clk);
      op_valid = 1'h0;
      chk("acc", e_acc, acc);
      chk("carry", e_c, borrow_inverse_flag);
      chk("half", e_half, half_borrow_inverse_flag);
      chk("null", e_z, null_result_flag);
      chk("file_we", to_file, file_we);
      if (to_file) begin
         chk("waddr", f, file_waddr);
         chk("wdata", r[7:0], file_wdata);
      end
   endtask : run

   task automatic reset_mid;
      @(negedge clk);
      rst = 1'h1;
      @(negedge clk);
      rst = 1'h0;
      e_acc = core_op_pkg::ACC_RST;
      e_c = core_op_pkg::CARRY_RST;
      e_half = core_op_pkg::HALF_RST;
      e_z = core_op_pkg::NULL_RST;
      chk("rst_ready", 1'h1, op_ready);
      chk("rst_asleep", 1'h0, asleep);
      chk("rst_timeout", core_op_pkg::TIMEOUT_RST, timeout_flag);
      chk("rst_power_down", core_op_pkg::POWER_DOWN_RST, power_down_flag);
      chk("rst_acc", e_acc, acc);
      chk("rst_flags", {e_c, e_half, e_z}, {borrow_inverse_flag, half_borrow_inverse_flag, null_result_flag});
      chk("rst_pulses", 5'h00, {file_we, stack_pop, pc_load, fetch_discard, watchdog_clear});
   endtask : reset_mid

   task automatic exit_sub;
      logic [12:0] h;
      @(negedge clk);
      h = stack_head;
      op_valid = 1'h1;
      op = core_op_pkg::op_sub_exit;
      @(negedge clk);
      op = core_op_pkg::op_lit_minus;
      op_literal = 8'hA5;
      chk("pc_value", h, pc_value);
      chk("pc_load", 1'h1, pc_load);
      chk("pop", 1'h1, stack_pop);
      chk("discard", 1'h1, fetch_discard);
      chk("ready_gap", 1'h0, op_ready);
      @(negedge clk);
      op_valid = 1'h0;
      chk("acc_gap", e_acc, acc);
      chk("pop_once", 1'h0, stack_pop);
      chk("ready_back", 1'h1, op_ready);
   endtask : exit_sub

   task automatic halt_wake;
      @(negedge clk);
      op_valid = 1'h1;
      op = core_op_pkg::op_halt;
      @(negedge clk);
      op = core_op_pkg::op_lit_minus;
      op_literal = 8'h3C;
      chk("wd_clear", 1'h1, watchdog_clear);
      chk("power_down", core_op_pkg::POWER_DOWN_ON_HALT, power_down_flag);
      chk("timeout", core_op_pkg::TIMEOUT_ON_HALT, timeout_flag);
      chk("asleep", 1'h1, asleep);
      chk("ready_sleep", 1'h0, op_ready);
      repeat (3) @(negedge clk);
      chk("wd_pulse", 1'h0, watchdog_clear);
      chk("acc_sleep", e_acc, acc);
      chk("still_asleep", 1'h1, asleep);
      wake = 1'h1;
      @(negedge clk);
      wake = 1'h0;
      op_valid = 1'h0;
      chk("awake", 1'h0, asleep);
      chk("acc_wake", e_acc, acc);
      chk("ready_wake", 1'h1, op_ready);
   endtask : halt_wake

   // ---------------------------------------
   // main sequence
   // ---------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      foreach (lits[i]) begin
         run(core_op_pkg::op_lit_minus, lits[i], 7'h00, 1'h0);
      end
      for (int i = 0; i < 6; i++) begin
         run(core_op_pkg::op_file_minus, 8'h00, 7'(i * 45 + 1), 1'(i));
         run(core_op_pkg::op_rotate, 8'h00, 7'(i * 19 + 3), 1'(i >> 1));
      end
      run(core_op_pkg::op_file_minus, 8'h00, 7'h2E, 1'h0);
      exit_sub();
      exit_sub();
      halt_wake();
      run(core_op_pkg::op_lit_minus, 8'h80, 7'h00, 1'h0);
      reset_mid();
      run(core_op_pkg::op_lit_minus, 8'h01, 7'h00, 1'h0);
      end_sim();
   end

   initial begin
      #20000;
      mismatches++;
      end_sim();
   end
endmodule : core_op_exec_tb
